// File: rtl/elx_link_training_state_machine.sv
// Link training state machine: disabled, inactive and receiver detect states
`timescale 1ns/1ns
`include "elx_defs.svh"
// Behaviour
// R1 - Disabled: no LFPS or SuperSpeed signalling
// R2 - Downstream leaves Disabled only when directed
// R3 - Hub upstream leaves on VBUS valid/bus reset
// R4 - Attempt counter clears: VBUS invalid, config ok
// R5 - Attempt counter increments entering Disabled.Default
// R6 - Default to detect: VBUS rise, reset below 3
// R7 - Attempt count 3 moves Default to Error
// R8 - Error returns to detect on power-on reset
// R9 - Error ignores bus reset; self-powered VBUS drop
// R10 - Inactive exits only by direction, absence, warm
// R11 - Quiet: detection off, 12 ms timer
// R12 - Quiet exits: disable, warm reset issue/detect
// R13 - Disconnect detect: absent to detect, else quiet
// R14 - Detect entered at power-on and warm reset
// R15 - Non-warm entry leaves reset substate at once
// R16 - Downstream drives warm reset full duration
// R17 - Upstream holds reset while warm LFPS continues
// R18 - Active runs detection, upstream counts events
// R19 - Peripheral disabled after eight absent detections
// R20 - Termination found moves Active to Polling
// R21 - Timers tick free-running, cleared on entry
// R22 - Power-on: reset substate, counter zero, no warm
module elx_link_training_state_machine #(
  parameter int unsigned CYC_PER_MS    = `ELX_NS_PER_MS / `ELX_CLK_NS,
  parameter logic [7:0]  WARM_RESET_MS = `ELX_WARM_MS
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Port role straps
  input  wire logic                is_downstream,
  input  wire logic                is_peripheral,
  input  wire logic                self_powered,
  // Power and USB 2.0 events
  input  wire logic                vbus_valid,
  input  wire logic                usb2_bus_reset,
  input  wire logic                cfg_exchange_ok,
  // Controller directives
  input  wire logic                dir_disable,
  input  wire logic                dir_rx_detect,
  input  wire logic                dir_warm_reset,
  input  wire logic                enter_inactive,
  // Link partner signalling
  input  wire logic                warm_reset_lfps_rx,
  input  wire logic                term_det_done,
  input  wire logic                term_det_present,
  // Link controls
  output logic                     ss_signal_en,
  output logic                     rx_term_low_imp,
  output logic                     term_det_en,
  output logic                     warm_reset_tx,
  // Status
  output elx_pkg::elx_state_t      link_state,
  output logic [1:0]               disabled_attempt_count,
  output logic [3:0]               det_event_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  elx_pkg::elx_state_t state_q;
  elx_pkg::elx_state_t state_d;
  logic                warm_q;
  logic                warm_d;
  logic                vbus_q;
  logic [1:0]          dis_cnt_q;
  logic [1:0]          dis_cnt_d;
  logic [3:0]          det_cnt_q;
  logic [3:0]          det_cnt_d;
  logic                periph;
  logic                vbus_rise;
  logic                in_dis;
  logic                warm_ev;
  logic                force_dis;
  logic                entering;
  logic                enter_def;
  logic                enter_rxd;
  logic                det_absent;
  logic                det_last;
  logic                ms_tick;
  logic                tmr_exp;
  logic [7:0]          tmr_target;

  // Any of the three disabled states
  function automatic logic is_dis(input elx_pkg::elx_state_t s);
    is_dis = (s == elx_pkg::ELX_DIS) || (s == elx_pkg::ELX_DEF) || (s == elx_pkg::ELX_ERR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Event decode

  // Role, edges and global overrides
  assign periph     = !is_downstream && is_peripheral;
  assign vbus_rise  = vbus_valid && !vbus_q;
  assign in_dis     = is_dis(state_q);
  assign warm_ev    = !in_dis && (state_q != elx_pkg::ELX_RXR) &&
                      (is_downstream ? dir_warm_reset : warm_reset_lfps_rx); // [R14]
  assign force_dis  = !in_dis && ((is_downstream && dir_disable) ||
                      (!is_downstream && self_powered && !vbus_valid)); // [R12]
  assign det_absent = term_det_done && !term_det_present;
  assign det_last   = (det_cnt_q + `ELX_DET_ONE) >= `ELX_DET_LIMIT;

  // Substate entry strobes
  assign entering   = (state_d != state_q);
  assign enter_def  = entering && (state_d == elx_pkg::ELX_DEF);
  assign enter_rxd  = entering && (state_d == elx_pkg::ELX_RXR);

  ////////////////////////////////////////////////////////////////////////////
  // Timers

  // Shared tick, timer target chosen by current substate
  assign tmr_target = (state_q == elx_pkg::ELX_IQ)  ? `ELX_QUIET_MS :
                      (state_q == elx_pkg::ELX_RXQ) ? `ELX_RXQ_MS  : WARM_RESET_MS;

  elx_ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ms_tick (ms_tick)   // [R21]
  );

  elx_ms_timer u_timer (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .clear     (entering),   // [R21]
    .ms_tick   (ms_tick),
    .target_ms (tmr_target),
    .expired   (tmr_exp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Per-substate exits, then warm reset and forced disable override
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      elx_pkg::ELX_DIS:
      begin
        if (is_downstream ? dir_rx_detect : (vbus_rise || usb2_bus_reset)) // [R2] [R3]
          state_d = elx_pkg::ELX_RXR;
      end
      elx_pkg::ELX_DEF:
      begin
        if (vbus_rise)
          state_d = elx_pkg::ELX_RXR;                 // [R6]
        else if (dis_cnt_q == `ELX_DIS_LIMIT)
          state_d = elx_pkg::ELX_ERR;                 // [R7]
        else if (usb2_bus_reset)
          state_d = elx_pkg::ELX_RXR;                 // [R6]
      end
      elx_pkg::ELX_ERR:
      begin
        if (self_powered && !vbus_valid)
          state_d = elx_pkg::ELX_DEF;                 // [R9]
      end
      elx_pkg::ELX_IQ:
      begin
        if (tmr_exp)
          state_d = elx_pkg::ELX_IDD;                 // [R11]
      end
      elx_pkg::ELX_IDD:
      begin
        if (term_det_done)
          state_d = term_det_present ? elx_pkg::ELX_IQ : elx_pkg::ELX_RXR; // [R13]
      end
      elx_pkg::ELX_RXR:
      begin
        if (!warm_q)
          state_d = elx_pkg::ELX_RXA;                 // [R15]
        else if (is_downstream ? tmr_exp : !warm_reset_lfps_rx) // [R16] [R17]
          state_d = elx_pkg::ELX_RXA;
      end
      elx_pkg::ELX_RXA:
      begin
        if (term_det_done && term_det_present)
          state_d = elx_pkg::ELX_POLL;                // [R20]
        else if (det_absent)
          state_d = (periph && det_last) ? elx_pkg::ELX_DEF : elx_pkg::ELX_RXQ; // [R19]
      end
      elx_pkg::ELX_RXQ:
      begin
        if (tmr_exp)
          state_d = elx_pkg::ELX_RXA;
      end
      elx_pkg::ELX_POLL:
      begin
        if (enter_inactive)
          state_d = elx_pkg::ELX_IQ;
      end
      default:
      begin
        state_d = elx_pkg::ELX_RXR;
      end
    endcase
    if (warm_ev)
      state_d = elx_pkg::ELX_RXR;                     // [R12] [R10]
    if (force_dis)
      state_d = periph ? elx_pkg::ELX_DEF : elx_pkg::ELX_DIS; // [R12]
  end

  // Warm reason held only while in the reset substate
  assign warm_d = (state_d != elx_pkg::ELX_RXR) ? 1'b0 :
                  (state_q == elx_pkg::ELX_RXR) ? warm_q : warm_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Counters

  // Attempt counter: entry increment wins over clear, saturates at limit
  assign dis_cnt_d = (periph && enter_def) ?
                       ((dis_cnt_q == `ELX_DIS_LIMIT) ? dis_cnt_q : dis_cnt_q + `ELX_DIS_ONE) : // [R5]
                     (!vbus_valid || cfg_exchange_ok) ? `ELX_ZERO2 : dis_cnt_q; // [R4]

  // Detection events counted by upstream ports across one detect visit
  assign det_cnt_d = enter_rxd ? `ELX_ZERO4 :
                     (!is_downstream && term_det_done && (state_q == elx_pkg::ELX_RXA) &&
                      (det_cnt_q != `ELX_DET_LIMIT)) ? det_cnt_q + `ELX_DET_ONE : det_cnt_q; // [R18]

  ////////////////////////////////////////////////////////////////////////////
  // State registers

  // Power-on lands in the reset substate without warm reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= elx_pkg::ELX_RXR;                  // [R22] [R8] [R14]
      warm_q    <= 1'b0;
      vbus_q    <= 1'b0;
      dis_cnt_q <= `ELX_ZERO2;
      det_cnt_q <= `ELX_ZERO4;
    end
    else
    begin
      state_q   <= state_d;
      warm_q    <= warm_d;
      vbus_q    <= vbus_valid;
      dis_cnt_q <= dis_cnt_d;
      det_cnt_q <= det_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Link controls decoded from registered state
  assign ss_signal_en           = !in_dis;            // [R1]
  assign rx_term_low_imp        = !in_dis;
  assign term_det_en            = (state_q == elx_pkg::ELX_RXA) || (state_q == elx_pkg::ELX_IDD); // [R11] [R18]
  assign warm_reset_tx          = is_downstream && warm_q && (state_q == elx_pkg::ELX_RXR); // [R16] [R22]
  assign link_state             = state_q;
  assign disabled_attempt_count = dis_cnt_q;
  assign det_event_count        = det_cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Cycles spent in inactive quiet
  logic [31:0] iq_cyc_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      iq_cyc_q <= 32'h0000_0000;
    else
      iq_cyc_q <= (state_q == elx_pkg::ELX_IQ) ? iq_cyc_q + 32'h0000_0001 : 32'h0000_0000;
  end

  // Cycles spent driving warm reset
  logic [31:0] warm_cyc_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      warm_cyc_q <= 32'h0000_0000;
    else
      warm_cyc_q <= warm_reset_tx ? warm_cyc_q + 32'h0000_0001 : 32'h0000_0000;
  end

  dis_silent_a: assert property (in_dis |-> !ss_signal_en && !term_det_en && !warm_reset_tx) // [R1]
    else $error("signalling enabled while disabled");
  ds_dis_hold_a: assert property (state_q == elx_pkg::ELX_DIS && is_downstream && !dir_rx_detect // [R2]
    |=> state_q == elx_pkg::ELX_DIS)
    else $error("downstream left disabled undirected");
  hub_dis_hold_a: assert property (state_q == elx_pkg::ELX_DIS && !is_downstream && !vbus_rise && // [R3]
    !usb2_bus_reset |=> state_q == elx_pkg::ELX_DIS)
    else $error("hub upstream left disabled without cause");
  cnt_clear_a: assert property ((!vbus_valid || cfg_exchange_ok) && !(periph && enter_def) // [R4]
    |=> dis_cnt_q == `ELX_ZERO2)
    else $error("attempt counter not cleared");
  cnt_incr_a: assert property (periph && enter_def && dis_cnt_q != `ELX_DIS_LIMIT // [R5]
    |=> dis_cnt_q == $past(dis_cnt_q) + `ELX_DIS_ONE)
    else $error("attempt counter not incremented");
  def_err_a: assert property (state_q == elx_pkg::ELX_DEF && dis_cnt_q == `ELX_DIS_LIMIT && !vbus_rise // [R7]
    |=> state_q == elx_pkg::ELX_ERR)
    else $error("count limit did not reach error");
  def_reset_a: assert property (state_q == elx_pkg::ELX_DEF && !vbus_rise && usb2_bus_reset && // [R6] [R15]
    dis_cnt_q < `ELX_DIS_LIMIT |=> state_q == elx_pkg::ELX_RXR ##1 state_q == elx_pkg::ELX_RXA)
    else $error("bus reset below limit not retried");
  err_hold_a: assert property (state_q == elx_pkg::ELX_ERR && !(self_powered && !vbus_valid) // [R9]
    |=> state_q == elx_pkg::ELX_ERR)
    else $error("error substate left");
  quiet_time_a: assert property (state_q == elx_pkg::ELX_IQ && state_d == elx_pkg::ELX_IDD // [R11]
    |-> iq_cyc_q + 32'h0000_0001 >= 32'(`ELX_QUIET_MS) * 32'(CYC_PER_MS))
    else $error("inactive quiet too short");
  quiet_long_a: assert property (state_q == elx_pkg::ELX_IQ // [R11]
    |-> iq_cyc_q < (32'(`ELX_QUIET_MS) + 32'(`ELX_SLACK_MS)) * 32'(CYC_PER_MS))
    else $error("inactive quiet too long");
  quiet_warm_a: assert property (state_q == elx_pkg::ELX_IQ && warm_ev && !force_dis // [R12]
    |=> state_q == elx_pkg::ELX_RXR && warm_q)
    else $error("warm reset did not leave inactive quiet");
  idd_exit_a: assert property (state_q == elx_pkg::ELX_IDD && det_absent && !force_dis && !warm_ev // [R13]
    |=> state_q == elx_pkg::ELX_RXR && !warm_q)
    else $error("disconnect not sent to detect");
  idd_stay_a: assert property (state_q == elx_pkg::ELX_IDD && term_det_done && term_det_present && // [R13]
    !warm_ev && !force_dis |=> state_q == elx_pkg::ELX_IQ)
    else $error("termination present but quiet not resumed");
  rxr_exit_a: assert property (state_q == elx_pkg::ELX_RXR && !warm_q && !force_dis // [R15]
    |=> state_q == elx_pkg::ELX_RXA)
    else $error("reset substate not left at once");
  warm_short_a: assert property (warm_reset_tx && state_d == elx_pkg::ELX_RXA // [R16]
    |-> warm_cyc_q + 32'h0000_0001 >= 32'(WARM_RESET_MS) * 32'(CYC_PER_MS))
    else $error("warm reset driven too briefly");
  warm_long_a: assert property (warm_reset_tx // [R16]
    |-> warm_cyc_q < (32'(WARM_RESET_MS) + 32'(`ELX_SLACK_MS)) * 32'(CYC_PER_MS))
    else $error("warm reset driven too long");
  us_warm_a: assert property (state_q == elx_pkg::ELX_RXR && warm_q && !is_downstream && // [R17]
    warm_reset_lfps_rx && !force_dis |=> state_q == elx_pkg::ELX_RXR)
    else $error("upstream left reset during warm reset");
  us_warm_end_a: assert property (state_q == elx_pkg::ELX_RXR && warm_q && !is_downstream && // [R17]
    !warm_reset_lfps_rx && !force_dis |=> state_q == elx_pkg::ELX_RXA)
    else $error("upstream held reset after warm reset ended");
  det_count_a: assert property (!is_downstream && state_q == elx_pkg::ELX_RXA && term_det_done && // [R18]
    !warm_ev && det_cnt_q < `ELX_DET_LIMIT |=> det_cnt_q == $past(det_cnt_q) + `ELX_DET_ONE)
    else $error("detection event not counted");
  periph_dis_a: assert property (periph && state_q == elx_pkg::ELX_RXA && det_absent && !warm_ev && // [R19]
    !force_dis && det_cnt_q + `ELX_DET_ONE == `ELX_DET_LIMIT |=> state_q == elx_pkg::ELX_DEF)
    else $error("eighth absent detection did not disable");
  absent_quiet_a: assert property (state_q == elx_pkg::ELX_RXA && det_absent && !warm_ev && // [R19]
    !force_dis && !(periph && det_cnt_q + `ELX_DET_ONE == `ELX_DET_LIMIT) |=> state_q == elx_pkg::ELX_RXQ)
    else $error("absent detection did not quiet");
  poll_a: assert property (state_q == elx_pkg::ELX_RXA && term_det_done && term_det_present && // [R20]
    !force_dis && !warm_ev |=> state_q == elx_pkg::ELX_POLL)
    else $error("termination found but no polling");

  reach_err_c:  cover property (state_q == elx_pkg::ELX_DEF ##1 state_q == elx_pkg::ELX_ERR);
  reach_poll_c: cover property (state_q == elx_pkg::ELX_RXA ##1 state_q == elx_pkg::ELX_POLL);
  quiet_dd_c:   cover property (state_q == elx_pkg::ELX_IQ ##1 state_q == elx_pkg::ELX_IDD);
  warm_ds_c:    cover property (warm_reset_tx ##1 !warm_reset_tx && state_q == elx_pkg::ELX_RXA);
endmodule

// File: rtl/elx_defs.svh
// Timing counts and limits for the link disable, inactive and detect logic
`ifndef ELX_DEFS_SVH
`define ELX_DEFS_SVH
`define ELX_CLK_NS       10
`define ELX_NS_PER_MS    1000000
`define ELX_QUIET_MS     8'h0C
`define ELX_RXQ_MS       8'h0C
`define ELX_WARM_MS      8'h64
`define ELX_SLACK_MS     8'h02
`define ELX_DIS_LIMIT    2'h3
`define ELX_DIS_ONE      2'h1
`define ELX_DET_LIMIT    4'h8
`define ELX_DET_ONE      4'h1
`define ELX_ZERO2        2'h0
`define ELX_ZERO4        4'h0
`endif

// File: rtl/elx_pkg.sv
// State type of the link disable, inactive and detect logic
package elx_pkg;
  typedef enum logic [8:0]
  {
    ELX_RXR  = 9'h001,
    ELX_RXA  = 9'h002,
    ELX_RXQ  = 9'h004,
    ELX_POLL = 9'h008,
    ELX_IQ   = 9'h010,
    ELX_IDD  = 9'h020,
    ELX_DIS  = 9'h040,
    ELX_DEF  = 9'h080,
    ELX_ERR  = 9'h100
  } elx_state_t;
endpackage

// File: rtl/elx_ms_tick.sv
// Free-running millisecond tick divider
`timescale 1ns/1ns
module elx_ms_tick #(
  parameter int unsigned CYC_PER_MS = 100000
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Tick out
  output logic      ms_tick
);
  localparam int unsigned CW = $clog2(CYC_PER_MS + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          wrap;

  // Wrap detect and next count
  assign wrap    = (cnt_q == CW'(CYC_PER_MS - 1));
  assign cnt_d   = wrap ? '0 : cnt_q + CW'(1);
  assign ms_tick = wrap;

  // Divider counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

// File: rtl/elx_ms_timer.sv
// Millisecond timer cleared on substate entry
`timescale 1ns/1ns
module elx_ms_timer (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       clear,
  input  wire logic       ms_tick,
  input  wire logic [7:0] target_ms,
  // Status
  output logic            expired
);
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  // One tick beyond target, so a free-running tick never shortens the wait
  assign expired = (cnt_q > {1'b0, target_ms});
  assign cnt_d   = clear ? 9'h000 :
                   (ms_tick && !cnt_q[8]) ? cnt_q + 9'h001 : cnt_q;

  // Tick counter
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 9'h000;
    else
      cnt_q <= cnt_d;
  end
endmodule

// File: bench/elx_partner_model.sv
// Link partner model: answers termination detection and sends warm reset LFPS
`timescale 1ns/1ns
module elx_partner_model #(
  parameter int unsigned FAST_DLY = 1,
  parameter int unsigned SLOW_DLY = 6
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Bench controls
  input  wire logic connected,
  input  wire logic slow,
  input  wire logic send_warm,
  // Port under test
  input  wire logic term_det_en,
  output logic      term_det_done,
  output logic      term_det_present,
  output logic      warm_reset_lfps_rx
);
  logic [3:0] wait_q;
  logic       done_q;
  logic       pres_q;
  wire  [3:0] dly_w = slow ? SLOW_DLY[3:0] : FAST_DLY[3:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Detection result after a prompt or slow delay, one pulse per request
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
      pres_q <= 1'b0;
    end
    else if (!term_det_en || done_q)
    begin
      wait_q <= 4'h0;
      done_q <= 1'b0;
    end
    else if (wait_q == dly_w)
    begin
      wait_q <= 4'h0;
      done_q <= 1'b1;
      pres_q <= connected;
    end
    else
      wait_q <= wait_q + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result line is not held outside the pulse, so show the inverse there
  assign term_det_done      = done_q;
  assign term_det_present   = done_q ? pres_q : ~pres_q;
  assign warm_reset_lfps_rx = send_warm;
endmodule

// File: bench/test_elx_link_training_state_machine.sv
// Testbench for the disable, inactive and receiver detect state machine
`timescale 1ns/1ns
module test_elx_link_training_state_machine;
  logic ref_clk, rst_n, is_downstream, is_peripheral, self_powered, vbus_valid;
  logic usb2_bus_reset, cfg_exchange_ok, dir_disable, dir_rx_detect, dir_warm_reset;
  logic enter_inactive, warm_reset_lfps_rx, term_det_done, term_det_present;
  logic connected, slow, send_warm, ss_signal_en, rx_term_low_imp, term_det_en, warm_reset_tx;
  elx_pkg::elx_state_t link_state;
  logic [1:0] disabled_attempt_count;
  logic [3:0] det_event_count;
  int         n_mismatch = 0;
  int         num_checks = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Design, partner and clock
  elx_link_training_state_machine #(.CYC_PER_MS(10), .WARM_RESET_MS(8'h02)) dut (.ref_clk, .rst_n, .is_downstream,
    .is_peripheral, .self_powered, .vbus_valid, .usb2_bus_reset, .cfg_exchange_ok, .dir_disable,
    .dir_rx_detect, .dir_warm_reset, .enter_inactive, .warm_reset_lfps_rx, .term_det_done,
    .term_det_present, .ss_signal_en, .rx_term_low_imp, .term_det_en, .warm_reset_tx,
    .link_state, .disabled_attempt_count, .det_event_count);
  elx_partner_model partner (.ref_clk, .rst_n, .connected, .slow, .send_warm, .term_det_en,
    .term_det_done, .term_det_present, .warm_reset_lfps_rx);
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick(1);
    sig = 1'b0;
  endtask

  task automatic wait_st(input elx_pkg::elx_state_t st, input int max_cyc);
    for (int i = 0; i < max_cyc && link_state !== st; i++) tick(1);
    chk(link_state, st);
  endtask

  task automatic restart(input logic ds, input logic per, input logic cn);
    rst_n = 1'b0;
    is_downstream = ds;
    is_peripheral = per;
    connected = cn;
    tick(4);
    chk(link_state, elx_pkg::ELX_RXR);
    chk({disabled_attempt_count, det_event_count, warm_reset_tx}, 16'h0000);
    rst_n = 1'b1;
    wait_st(elx_pkg::ELX_RXA, 3);
    chk(term_det_en, 16'h0001);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hub upstream: inactive loop, warm reset, disconnect, VBUS loss
  task automatic t_hub;
    self_powered = 1'b1;
    restart(1'b0, 1'b0, 1'b1);
    wait_st(elx_pkg::ELX_POLL, 10);
    pulse(enter_inactive);
    chk({link_state, term_det_en}, {elx_pkg::ELX_IQ, 1'b0});
    tick(110);
    chk(link_state, elx_pkg::ELX_IQ);
    wait_st(elx_pkg::ELX_IDD, 40);
    chk(term_det_en, 16'h0001);
    wait_st(elx_pkg::ELX_IQ, 10);
    send_warm = 1'b1;
    wait_st(elx_pkg::ELX_RXR, 3);
    tick(30);
    chk(link_state, elx_pkg::ELX_RXR);
    send_warm = 1'b0;
    wait_st(elx_pkg::ELX_RXA, 3);
    wait_st(elx_pkg::ELX_POLL, 10);
    pulse(enter_inactive);
    connected = 1'b0;
    wait_st(elx_pkg::ELX_RXR, 200);
    wait_st(elx_pkg::ELX_RXA, 3);
    vbus_valid = 1'b0;
    wait_st(elx_pkg::ELX_DIS, 3);
    chk({ss_signal_en, rx_term_low_imp}, 16'h0000);
    tick(10);
    chk(link_state, elx_pkg::ELX_DIS);
    vbus_valid = 1'b1;
    wait_st(elx_pkg::ELX_RXA, 3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Downstream: warm reset length, disable mid-reset, directives
  task automatic t_downstream;
    int n;
    self_powered = 1'b0;
    restart(1'b1, 1'b0, 1'b1);
    wait_st(elx_pkg::ELX_POLL, 10);
    pulse(dir_warm_reset);
    chk(link_state, elx_pkg::ELX_RXR);
    n = 0;
    while (warm_reset_tx === 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    chk(n >= 20 && n <= 31, 16'h0001);
    wait_st(elx_pkg::ELX_POLL, 10);
    pulse(dir_warm_reset);
    tick(5);
    chk(warm_reset_tx, 16'h0001);
    pulse(dir_disable);
    chk({link_state, warm_reset_tx}, {elx_pkg::ELX_DIS, 1'b0});
    pulse(dir_warm_reset);
    tick(10);
    chk({link_state, ss_signal_en}, {elx_pkg::ELX_DIS, 1'b0});
    pulse(dir_rx_detect);
    wait_st(elx_pkg::ELX_RXA, 3);
    wait_st(elx_pkg::ELX_POLL, 10);
    pulse(enter_inactive);
    pulse(dir_disable);
    chk(link_state, elx_pkg::ELX_DIS);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Peripheral: eight absent detections, attempt counter, error substate
  task automatic t_peripheral;
    self_powered = 1'b0;
    restart(1'b0, 1'b1, 1'b0);
    slow = 1'b1;
    wait_st(elx_pkg::ELX_DEF, 1500);
    tick(2);
    chk(disabled_attempt_count, 16'h0001);
    chk(det_event_count, 16'h0008);
    chk({ss_signal_en, rx_term_low_imp}, 16'h0000);
    pulse(cfg_exchange_ok);
    tick(1);
    chk(disabled_attempt_count, 16'h0000);
    for (int k = 1; k <= 3; k++)
    begin
      pulse(usb2_bus_reset);
      wait_st(elx_pkg::ELX_RXA, 3);
      wait_st(elx_pkg::ELX_DEF, 1500);
      tick(2);
      chk(disabled_attempt_count, 16'(k));
    end
    wait_st(elx_pkg::ELX_ERR, 3);
    vbus_valid = 1'b0;
    tick(2);
    chk({link_state, disabled_attempt_count}, {elx_pkg::ELX_ERR, 2'h0});
    vbus_valid = 1'b1;
    pulse(usb2_bus_reset);
    tick(10);
    chk(link_state, elx_pkg::ELX_ERR);
    rst_n = 1'b0;
    tick(1);
    rst_n = 1'b1;
    wait_st(elx_pkg::ELX_RXA, 3);
    chk(disabled_attempt_count, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {ref_clk, rst_n, is_downstream, is_peripheral, self_powered, usb2_bus_reset} = 6'h00;
    {cfg_exchange_ok, dir_disable, dir_rx_detect, dir_warm_reset, enter_inactive} = 5'h00;
    {connected, slow, send_warm} = 3'h0;
    vbus_valid = 1'b1;
    t_hub;
    t_downstream;
    t_peripheral;
    finish_test;
  end

  // Watchdog against a hang
  initial
  begin
    #500000;
    n_mismatch++;
    finish_test;
  end
endmodule
